/* File: logic/iac_top.sv */
`default_nettype none
// Notes on behaviour
// - bit depth 7..13, default when unset
// - depth change stops a running conversion
// - full stop powers down integrator, timer
// - start takes 8-bit count, 0 continuous
// - halt stops at once, power kept
// - ready flag nonzero after a conversion
// - result kept until next overwrites it
// - clear command zeroes ready flag
// - read-and-clear returns result, clears flag
// - compare 2^(depth+2), period adds calc time
// - integrator switch 0 off, 1 on
// - unsigned 0..2^N, signed centred on zero
module iac_top
   import iac_pkg::*;
#(
   parameter logic [3:0]  DEFAULT_DEPTH = DEPTH_RST,
   parameter logic [15:0] DEFAULT_CALC  = CALC_RST
)(
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        comparator_i,
   output logic             integrator_switch_control_o,
   output logic             analog_power_o,
   output logic             irq_o
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {S_OFF, S_IDLE, S_RUN} iac_state_e;
   iac_state_e  state;
   logic [3:0]  bit_depth_value;
   logic [15:0] calculation_time;
   logic [7:0]  sample_run_count;
   logic        continuous;
   logic        signed_fmt;
   logic        result_ready;
   logic [15:0] result_hold;
   logic [1:0]  irq_stat;
   logic [1:0]  irq_mask;
   logic [2:0]  cmp_sync;
   logic        cmp_lvl;
   logic        wr_acc;
   logic        rd_acc;
   logic        running;
   logic        integ;
   logic        period_end;
   logic [15:0] raw_count;
   logic [15:0] next_result;
   logic        run_end;
   logic        depth_wr;
   logic        ctrl_wr;
   logic        start_cmd;
   logic        halt_cmd;
   logic        off_cmd;
   logic        clr_cmd;
   logic        rdclr;
   logic        mapped;
   logic [31:0] rd_mux;
   logic [1:0]  irq_event;
   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   assign pready  = 1'b1;
   assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= ADDR_IRQMSK);
   assign pslverr = psel && penable && !mapped;
   assign wr_acc  = psel && penable && pwrite && mapped;
   assign rd_acc  = psel && penable && !pwrite && mapped;
   assign ctrl_wr   = wr_acc && (paddr == ADDR_CTRL);
   assign depth_wr  = wr_acc && (paddr == ADDR_DEPTH);
   assign start_cmd = ctrl_wr && pwdata[CTRL_START_BIT];
   assign halt_cmd  = ctrl_wr && pwdata[CTRL_HALT_BIT];
   assign off_cmd   = ctrl_wr && pwdata[CTRL_OFF_BIT];
   assign clr_cmd   = ctrl_wr && pwdata[CTRL_CLEAR_BIT];
   assign rdclr     = rd_acc && (paddr == ADDR_DATACL);
   assign running   = (state == S_RUN);
   // ---------------------------------------------------------------
   // comparator synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmp_sync <= 3'h0;
         cmp_lvl  <= 1'b0;
      end else begin
         cmp_sync <= {cmp_sync[1:0], comparator_i};
         if (cmp_sync[1] == cmp_sync[2]) begin
            cmp_lvl <= cmp_sync[2];
         end
      end
   end
   // ---------------------------------------------------------------
   // timer and counter
   // ---------------------------------------------------------------
   iac_timer u_timer (
      .mclk_i       (mclk_i),
      .rst_n_i      (rst_n_i),
      .run_i        (running),
      .depth_i      (bit_depth_value),
      .calc_i       (calculation_time),
      .integ_o      (integ),
      .period_end_o (period_end)
   );
   iac_counter u_count (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .clr_i   (!running || period_end),
      .integ_i (integ),
      .cmp_i   (cmp_lvl),
      .count_o (raw_count)
   );
   assign integrator_switch_control_o = integ;
   always_comb begin
      next_result = raw_count;
      if (signed_fmt) begin
         next_result = raw_count - (16'h0001 << (bit_depth_value - 4'h1));
      end
   end
   assign run_end = period_end && !continuous &&
                    (sample_run_count == 8'h01);
   // ---------------------------------------------------------------
   // configuration
   // ---------------------------------------------------------------
   // depth range and default
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bit_depth_value <= DEFAULT_DEPTH;
      end else if (depth_wr && pwdata[3:0] >= DEPTH_MIN &&
                   pwdata[3:0] <= DEPTH_MAX) begin
         bit_depth_value <= pwdata[3:0];
      end
   end
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         calculation_time <= DEFAULT_CALC;
      end else if (wr_acc && paddr == ADDR_CALC && !running) begin
         calculation_time <= pwdata[15:0];
      end
   end
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         signed_fmt <= 1'b1;
      end else if (ctrl_wr && !running) begin
         signed_fmt <= pwdata[CTRL_SIGNED_BIT];
      end
   end
   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state            <= S_OFF;
         sample_run_count <= 8'h00;
         continuous       <= 1'b0;
      end else begin
         unique case (state)
            S_OFF: begin
               if (ctrl_wr && pwdata[CTRL_POWER_BIT] && !off_cmd) begin
                  state <= S_IDLE;
               end
            end
            S_IDLE: begin
               if (off_cmd) begin
                  state <= S_OFF;
               end else if (start_cmd && !halt_cmd) begin
                  state            <= S_RUN;
                  sample_run_count <= pwdata[CTRL_COUNT_LSB +: 8];
                  continuous       <= (pwdata[CTRL_COUNT_LSB +: 8] == 8'h00);
               end
            end
            S_RUN: begin
               if (off_cmd) begin
                  state <= S_OFF;
               end else if (halt_cmd || depth_wr) begin
                  state <= S_IDLE;
               end else if (period_end && !continuous) begin
                  sample_run_count <= sample_run_count - 8'h01;
                  if (run_end) begin
                     state <= S_IDLE;
                  end
               end
            end
         endcase
      end
   end
   assign analog_power_o = (state != S_OFF);
   // ---------------------------------------------------------------
   // result and ready flag
   // ---------------------------------------------------------------
   // overwrite on completion
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result_hold <= 16'h0000;
      end else if (period_end) begin
         result_hold <= next_result;
      end
   end
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result_ready <= 1'b0;
      end else if (period_end) begin
         result_ready <= 1'b1;
      end else if (clr_cmd || rdclr) begin
         result_ready <= 1'b0;
      end
   end
   // ---------------------------------------------------------------
   // interrupts
   // ---------------------------------------------------------------
   always_comb begin
      irq_event                 = 2'h0;
      irq_event[IRQ_DONE_BIT]   = period_end;
      irq_event[IRQ_RUNEND_BIT] = run_end;
   end
   // per-bit sticky status, set beats write-one-to-clear
   for (genvar g = 0; g < 2; g++) begin : g_irq
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            irq_stat[g] <= IRQ_RST[g];
         end else if (irq_event[g]) begin
            irq_stat[g] <= 1'b1;
         end else if (wr_acc && paddr == ADDR_IRQST && pwdata[g]) begin
            irq_stat[g] <= 1'b0;
         end
      end
   end
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_mask <= IRQ_RST;
      end else if (wr_acc && paddr == ADDR_IRQMSK) begin
         irq_mask <= pwdata[1:0];
      end
   end
   assign irq_o = |(irq_stat & irq_mask);
   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   iac_stat_s st;
   assign st = '{run: running, continuous: continuous,
                 powered: analog_power_o, integ_en: integ};
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         ADDR_CTRL:   rd_mux = {16'h0000, sample_run_count, 2'h0,
                                signed_fmt, analog_power_o, 4'h0};
         ADDR_DEPTH:  rd_mux = {28'h0000000, bit_depth_value};
         ADDR_STAT:   rd_mux = {27'h0000000, st, result_ready};
         ADDR_DATA:   rd_mux = {16'h0000, result_hold};
         ADDR_DATACL: rd_mux = {16'h0000, result_hold};
         ADDR_CALC:   rd_mux = {16'h0000, calculation_time};
         ADDR_IRQST:  rd_mux = {30'h00000000, irq_stat};
         ADDR_IRQMSK: rd_mux = {30'h00000000, irq_mask};
         default:     rd_mux = 32'h0000_0000;
      endcase
   end
   // read word captured in setup phase, shown only in access phase;
   // a result landing between the two is not seen by that read
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite && mapped) begin
         prdata <= rd_mux;
      end else begin
         prdata <= 32'h0000_0000;
      end
   end
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   stop_on_halt_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      halt_cmd && running |=> !running && analog_power_o)
      else $error("halt did not stop run");
   off_powers_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      off_cmd |=> !analog_power_o && !integrator_switch_control_o)
      else $error("full stop left power on");
   depth_stop_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      depth_wr && running |=> !running)
      else $error("depth change kept running");
   depth_range_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      bit_depth_value >= DEPTH_MIN && bit_depth_value <= DEPTH_MAX)
      else $error("depth out of range");
   ready_set_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      period_end |=> result_ready && result_hold == $past(next_result))
      else $error("result not loaded with flag");
   clear_flag_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (clr_cmd || rdclr) && !period_end |=> !result_ready)
      else $error("flag not cleared");
   hold_result_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      !period_end |=> $stable(result_hold))
      else $error("result changed early");
   run_end_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      run_end && !halt_cmd && !off_cmd && !depth_wr |=> !running)
      else $error("finite run did not stop");
   continuous_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      start_cmd && state == S_IDLE && !halt_cmd && !off_cmd &&
      pwdata[CTRL_COUNT_LSB +: 8] == 8'h00 |=> running && continuous)
      else $error("zero count not continuous");
   switch_idle_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      !running |-> !integrator_switch_control_o)
      else $error("integrator enabled while idle");
   run_power_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      running |-> analog_power_o)
      else $error("running while powered down");
   count_down_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      running && period_end && !continuous && !halt_cmd && !off_cmd &&
      !depth_wr |=> sample_run_count == $past(sample_run_count) - 8'h01)
      else $error("sample count not decremented");
   unsigned_load_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      period_end && !signed_fmt |=> result_hold == $past(raw_count))
      else $error("unsigned result not raw count");
   stat_read_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      psel && !penable && !pwrite && paddr == ADDR_STAT |=>
         prdata[0] == $past(result_ready))
      else $error("ready flag not shown");
   read_clear_data_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      psel && !penable && !pwrite && paddr == ADDR_DATACL |=>
         prdata == {16'h0000, $past(result_hold)})
      else $error("read-and-clear data wrong");
endmodule
`default_nettype wire

/* File: logic/iac_pkg.sv */
`default_nettype none
package iac_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_DEPTH  = 8'h04;
   localparam logic [7:0] ADDR_STAT   = 8'h08;
   localparam logic [7:0] ADDR_DATA   = 8'h0C;
   localparam logic [7:0] ADDR_DATACL = 8'h10;
   localparam logic [7:0] ADDR_CALC   = 8'h14;
   localparam logic [7:0] ADDR_IRQST  = 8'h18;
   localparam logic [7:0] ADDR_IRQMSK = 8'h1C;
   // ---------------------------------------------------------------
   // control fields
   // ---------------------------------------------------------------
   localparam int CTRL_START_BIT  = 0;
   localparam int CTRL_HALT_BIT   = 1;
   localparam int CTRL_OFF_BIT    = 2;
   localparam int CTRL_CLEAR_BIT  = 3;
   localparam int CTRL_POWER_BIT  = 4;
   localparam int CTRL_SIGNED_BIT = 5;
   localparam int CTRL_COUNT_LSB  = 8;
   localparam int IRQ_DONE_BIT    = 0;
   localparam int IRQ_RUNEND_BIT  = 1;
   // ---------------------------------------------------------------
   // limits and resets
   // ---------------------------------------------------------------
   localparam logic [3:0]  DEPTH_MIN   = 4'h7;
   localparam logic [3:0]  DEPTH_MAX   = 4'hD;
   localparam logic [3:0]  DEPTH_RST   = 4'hA;
   localparam logic [15:0] CALC_RST    = 16'h002D;
   localparam logic [1:0]  IRQ_RST     = 2'h0;
   localparam int          RES_W       = 16;
   typedef struct packed {
      logic       run;
      logic       continuous;
      logic       powered;
      logic       integ_en;
   } iac_stat_s;
endpackage
`default_nettype wire

/* File: logic/iac_timer.sv */
`default_nettype none
// integration period timer: integrate window then calculation gap
module iac_timer
   import iac_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        run_i,
   input  wire logic [3:0]  depth_i,
   input  wire logic [15:0] calc_i,
   output logic             integ_o,
   output logic             period_end_o
);
   logic [16:0] cnt;
   logic [16:0] cmp;
   logic [16:0] per;
   assign cmp = 17'h00001 << (depth_i + 4'h2);
   assign per = cmp + {1'b0, calc_i};
   assign period_end_o = run_i && (cnt == per - 17'h00001);
   assign integ_o      = run_i && (cnt < cmp);
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= 17'h00000;
      end else if (!run_i || period_end_o) begin
         cnt <= 17'h00000;
      end else begin
         cnt <= cnt + 17'h00001;
      end
   end
endmodule
`default_nettype wire

/* File: logic/iac_counter.sv */
`default_nettype none
// counts comparator-high cycles during integration, one per 4 clocks
module iac_counter
   import iac_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        clr_i,
   input  wire logic        integ_i,
   input  wire logic        cmp_i,
   output logic [15:0]      count_o
);
   logic [1:0] ph;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ph      <= 2'h0;
         count_o <= 16'h0000;
      end else if (clr_i) begin
         ph      <= 2'h0;
         count_o <= 16'h0000;
      end else if (integ_i) begin
         ph <= ph + 2'h1;
         if (ph == 2'h3 && cmp_i) begin
            count_o <= count_o + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

/* File: verification/iac_front_model.sv */
`default_nettype none
module iac_front_model (
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   input  wire logic powered_i,
   input  wire logic half_i,
   output logic      comparator_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] phase;
   // ---------------------------------------------------------------
   // comparator level: low, or 8 high / 8 low; noise when unpowered
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase        <= 4'h0;
         comparator_o <= 1'b0;
      end else begin
         phase <= phase + 4'h1;
         if (!powered_i)
            comparator_o <= ~comparator_o;
         else if (half_i)
            comparator_o <= phase[3];
         else
            comparator_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: verification/incremental_adc_sequencer_tb_top.sv */
`default_nettype none
module incremental_adc_sequencer_tb_top
   import iac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk_i, rst_n_i, psel, penable, pwrite, half;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic        pready, pslverr, cmp, integ, power, irq, e;
   int          error_cnt, num_checks, cyc, hi_cnt, hi_len, per_len, rise;
   logic        integ_q;
   // ---------------------------------------------------------------
   // design and front end
   // ---------------------------------------------------------------
   iac_top u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .comparator_i(cmp),
      .integrator_switch_control_o(integ), .analog_power_o(power),
      .irq_o(irq));
   iac_front_model u_front (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .powered_i(power), .half_i(half), .comparator_o(cmp));
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end
   // ---------------------------------------------------------------
   // integrate window and period monitor
   // ---------------------------------------------------------------
   always @(posedge mclk_i) begin
      cyc++;
      if (integ === 1'b1 && integ_q !== 1'b1) begin
         per_len = cyc - rise;
         rise = cyc;
         hi_cnt = 0;
      end
      if (integ === 1'b1) hi_cnt++;
      if (integ !== 1'b1 && integ_q === 1'b1) hi_len = hi_cnt;
      integ_q = integ;
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic check(input string w, input logic [31:0] s, x);
      num_checks++;
      if (s !== x) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", w, x, s);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic timeout(input string w);
      error_cnt++;
      $display("mismatch %s expected done seen timeout", w);
      finish_test();
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
      int n;
      @(posedge mclk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) timeout("pready");
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        err;
      apb(1'b1, a, d, q, err);
   endtask
   task automatic apb_rd(input logic [7:0] a, output logic [31:0] q);
      logic err;
      apb(1'b0, a, 32'h0, q, err);
   endtask
   task automatic wait_flag;
      logic [31:0] s;
      s = 32'h0;
      for (int i = 0; i < 600 && s[0] !== 1'b1; i++) apb_rd(ADDR_STAT, s);
      if (s[0] !== 1'b1) timeout("ready flag");
   endtask
   task automatic wait_integ;
      for (int i = 0; i < 1000 && integ !== 1'b1; i++) @(posedge mclk_i);
      if (integ !== 1'b1) timeout("integrate");
   endtask
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n_i = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      half = 1'b0;
      error_cnt = 0;
      num_checks = 0;
      repeat (12) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      apb_rd(ADDR_DEPTH, r);
      check("depth reset", 32'(r[3:0]), 32'hA);
      apb(1'b0, 8'h20, 32'h0, r, e);
      check("unmapped err", {31'h0, e}, 32'h1);
      check("unmapped data", r, 32'h0);
      for (int d = 6; d <= 14; d++) begin
         apb_wr(ADDR_DEPTH, 32'(d));
         apb_rd(ADDR_DEPTH, r);
         check("depth", 32'(r[3:0]), d < 7 ? 32'hA : d > 13 ? 32'hD : d);
      end
      apb_wr(ADDR_DEPTH, 32'h7);
      apb_wr(ADDR_CALC, 32'h8);
      apb_wr(ADDR_IRQMSK, 32'h3);
      apb_wr(ADDR_CTRL, 32'h10);
      half <= 1'b1;
      apb_wr(ADDR_CTRL, 32'h0201);
      wait_flag();
      apb_rd(ADDR_CTRL, r);
      check("count left", r & 32'hFF30, 32'h0110);
      apb_rd(ADDR_DATA, r);
      check("unsigned half", 32'(r[15:0]), 32'h40);
      #1 check("irq done", {31'h0, irq}, 32'h1);
      apb_rd(ADDR_DATACL, r);
      check("read clear", 32'(r[15:0]), 32'h40);
      apb_rd(ADDR_STAT, r);
      check("flag after rc", r & 32'h1, 32'h0);
      wait_flag();
      apb_rd(ADDR_STAT, r);
      check("run ended", r & 32'h11, 32'h01);
      apb_rd(ADDR_IRQST, r);
      check("irq status", r & 32'h3, 32'h3);
      apb_wr(ADDR_IRQMSK, 32'h0);
      #1 check("irq masked", {31'h0, irq}, 32'h0);
      apb_wr(ADDR_IRQST, 32'h3);
      apb_rd(ADDR_IRQST, r);
      check("irq w1c", r & 32'h3, 32'h0);
      half <= 1'b0;
      apb_wr(ADDR_CTRL, 32'h28);
      apb_wr(ADDR_CTRL, 32'h21);
      wait_flag();
      apb_rd(ADDR_DATA, r);
      check("signed low", 32'(r[15:0]), 32'hFFC0);
      apb_wr(ADDR_CTRL, 32'h28);
      apb_rd(ADDR_STAT, r);
      check("clear flag", r & 32'h1, 32'h0);
      half <= 1'b1;
      wait_flag();
      apb_wr(ADDR_CTRL, 32'h28);
      wait_flag();
      apb_rd(ADDR_DATA, r);
      check("overwritten", 32'(r[15:0]), 32'h0);
      apb_rd(ADDR_STAT, r);
      check("continuous", r & 32'h18, 32'h18);
      check("integrate len", 32'(hi_len), 32'd512);
      check("period len", 32'(per_len), 32'd520);
      wait_integ();
      apb_wr(ADDR_CTRL, 32'h22);
      @(posedge mclk_i);
      #1 check("halt integ", {31'h0, integ}, 32'h0);
      check("halt power", {31'h0, power}, 32'h1);
      apb_wr(ADDR_CTRL, 32'h21);
      wait_integ();
      apb_wr(ADDR_DEPTH, 32'h7);
      apb_rd(ADDR_STAT, r);
      check("depth stop", r & 32'h10, 32'h0);
      apb_wr(ADDR_CTRL, 32'h24);
      apb_rd(ADDR_STAT, r);
      check("full stop", r & 32'h14, 32'h0);
      #1 check("power off", {31'h0, power}, 32'h0);
      apb_wr(ADDR_CTRL, 32'h21);
      repeat (20) @(posedge mclk_i);
      #1 check("off no run", {31'h0, integ}, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
